// ==== rtl/bit_clock_gen.sv ====
// Free-running internal bit clock, a one-cycle tick restarted at every conversion start.
module bit_clock_gen #(
	parameter int unsigned DIV = sar_seq_pkg::BIT_CLK_DIV
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Control
	input wire logic restart,
	output logic tick
);
	localparam int unsigned CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_q, cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		tick = 1'b0;
		if (restart) begin
			cnt_d = '0;
		end else if (cnt_q == CW'(DIV - 1)) begin
			cnt_d = '0;
			tick = 1'b1;
		end else begin
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule

// ==== rtl/sar_acquisition_sequencer.sv ====
// Track/hold control, successive-approximation bit cycle, busy flag and byte-gated outputs.
// How it works
// RULE_01: While the convert pulse is high the sample stage tracks the input; the code holds instead while busy is high.
// RULE_02: The convert pulse falling edge puts the stage in hold, starts a conversion and resets the sequencing logic.
// RULE_03: The host keeps the convert pulse high at least 4 us or 5 us before driving it low.
// RULE_04: Convert pulses arriving during a conversion are ignored until it ends.
// RULE_05: At conversion start the top result bit goes low and all other bits go high.
// RULE_06: Busy rises at conversion start and stays high for the whole conversion.
// RULE_07: Each bit from the top down is switched low on an internal clock edge and decided by the comparator; the code switches each trial bit high instead.
// RULE_08: Each bit trial takes exactly one internal clock cycle.
// RULE_09: A conversion finishes within 35 us or 44 us.
// RULE_10: Busy falls when the last bit is decided, marking the result valid.
// RULE_11: After busy falls the host reads the result through the two byte gates.
// RULE_12: Each byte gate is active low; bits are driven only while their gate is low.
// RULE_13: Unipolar results are straight binary, bipolar ones offset binary or two's complement.
// RULE_14: Two's complement supplies the inverted top bit, the other codings the true top bit.
// RULE_15: The host may tie both gates low to keep the result driven.
// RULE_16: The final result stands unchanged until the next conversion starts.
module sar_acquisition_sequencer #(
	parameter int unsigned WIDTH = sar_seq_pkg::WIDTH_14,
	parameter int unsigned BIT_DIV = sar_seq_pkg::BIT_CLK_DIV
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Conversion control from the host
	input wire logic convert,
	input wire sar_seq_pkg::coding_t coding,
	// Analog front-end interface
	output logic hold,
	input wire logic comp_above,
	output logic [WIDTH-1:0] dac_code,
	// Status
	output logic busy,
	// Byte-gated result bus
	input wire logic upper_byte_output_gate_n,
	input wire logic lower_byte_output_gate_n,
	output logic [WIDTH-1:0] data_out,
	output logic [WIDTH-1:0] data_oe
);
	localparam int unsigned LOW_BITS = sar_seq_pkg::BYTE_BITS;
	localparam int unsigned IW = $clog2(WIDTH);
	localparam logic [WIDTH-1:0] START_CODE = {1'b0, {(WIDTH-1){1'b1}}};
	localparam logic [WIDTH-1:0] TOP_TRIAL = {1'b1, {(WIDTH-1){1'b0}}};
	localparam logic [IW-1:0] TOP_IDX = IW'(WIDTH - 1);

	// Convert pulse edge detector.
	logic convert_q;
	logic convert_d;
	logic fall;
	logic restart;

	// Sequencer control.
	sar_seq_pkg::seq_state_t state_q;
	sar_seq_pkg::seq_state_t state_d;
	logic [IW-1:0] idx_q;
	logic [IW-1:0] idx_d;
	logic busy_q;
	logic busy_d;
	logic tick;
	logic first_step;
	logic trial_step;
	logic last_step;

	// Trial register driving the DAC; each bit has its own slice driver.
	logic [WIDTH-1:0] sar_q;
	wire logic [WIDTH-1:0] sar_d;

	// Result latch behind the output buffers.
	logic [WIDTH-1:0] out_q;
	logic [WIDTH-1:0] out_d;

	// Converts the register to the selected output coding.
	function automatic logic [WIDTH-1:0] encode(
		input logic [WIDTH-1:0] v,
		input sar_seq_pkg::coding_t c
	);
		logic [WIDTH-1:0] r;
		r = v;
		if (c == sar_seq_pkg::CODE_TWOS) begin
			r[WIDTH-1] = ~v[WIDTH-1]; // RULE_14
		end
		return r; // RULE_13
	endfunction

	// Tells whether the trial index points at the given bit position.
	function automatic logic at_bit(
		input logic [IW-1:0] idx,
		input int unsigned pos
	);
		return 32'(idx) == pos;
	endfunction

	// Next value of one trial register bit; a load wins over a decision, a decision over a raise.
	function automatic logic trial_bit(
		input logic keep,
		input logic load,
		input logic load_val,
		input logic decide,
		input logic raise,
		input logic comp
	);
		logic r;
		r = keep;
		if (load) begin
			r = load_val;
		end else if (decide) begin
			r = comp;
		end else if (raise) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// Tells whether the byte gate that owns a bit position is asserted.
	function automatic logic gate_open(
		input int unsigned pos,
		input logic upper_n,
		input logic lower_n
	);
		logic r;
		r = !upper_n;
		if (pos < LOW_BITS) begin
			r = !lower_n;
		end
		return r;
	endfunction

	always_comb begin
		convert_d = convert;
	end

	// Resetting the copy low means a pulse that is already low at reset release never starts a conversion.
	always_ff @(posedge mclk) begin
		if (rst) begin
			convert_q <= 1'b0;
		end else begin
			convert_q <= convert_d;
		end
	end

	assign fall = convert_q && !convert;
	// A falling edge only counts while no conversion runs.
	assign restart = fall && !busy_q; // RULE_04

	bit_clock_gen #(
		.DIV(BIT_DIV)
	) u_bit_clk (
		.mclk(mclk),
		.rst(rst),
		.restart(restart),
		.tick(tick)
	);

	// Trial steps happen on internal clock ticks only.
	assign first_step = tick && (state_q == sar_seq_pkg::ST_START); // RULE_07
	assign trial_step = tick && (state_q == sar_seq_pkg::ST_TRIAL); // RULE_08
	assign last_step = trial_step && (idx_q == '0); // RULE_10

	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		busy_d = busy_q;
		case (state_q)
			sar_seq_pkg::ST_IDLE, sar_seq_pkg::ST_DONE: begin
				if (restart) begin
					idx_d = TOP_IDX; // RULE_02
					busy_d = 1'b1; // RULE_06
					state_d = sar_seq_pkg::ST_START;
				end
			end
			sar_seq_pkg::ST_START: begin
				if (first_step) begin
					state_d = sar_seq_pkg::ST_TRIAL;
				end
			end
			sar_seq_pkg::ST_TRIAL: begin
				if (last_step) begin
					busy_d = 1'b0; // RULE_10 RULE_09
					state_d = sar_seq_pkg::ST_DONE;
				end else if (trial_step) begin
					idx_d = idx_q - IW'(1); // RULE_08
				end
			end
			default: begin
				state_d = sar_seq_pkg::ST_IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= sar_seq_pkg::ST_IDLE;
			idx_q <= '0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx_q <= idx_d;
			busy_q <= busy_d;
		end
	end

	// Each slice is loaded at start, set to the top trial on the first tick, decided while under
	// trial and raised when it is the next one to be tried, so decision and next trial share an edge.
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			assign sar_d[g] = trial_bit(
				sar_q[g],
				restart || first_step,
				restart ? START_CODE[g] : TOP_TRIAL[g],
				trial_step && at_bit(idx_q, g),
				trial_step && !last_step && at_bit(idx_q, g + 1),
				comp_above
			); // RULE_05 RULE_07
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			sar_q <= '0;
		end else begin
			sar_q <= sar_d;
		end
	end

	// The latch changes only at a conversion start or at the last decision, so a read between
	// conversions always sees the finished result.
	always_comb begin
		out_d = out_q;
		if (restart) begin
			out_d = START_CODE; // RULE_05
		end else if (last_step) begin
			out_d = encode(sar_d, coding); // RULE_13
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			out_q <= '0;
		end else begin
			out_q <= out_d; // RULE_16
		end
	end

	// Hold follows the convert level once idle, and stays in hold through a conversion.
	assign hold = busy_q || !convert; // RULE_01 RULE_02
	assign busy = busy_q; // RULE_06
	assign dac_code = sar_q;
	assign data_out = out_q;

	generate
		for (g = 0; g < WIDTH; g++) begin : g_oe
			assign data_oe[g] = gate_open(g, upper_byte_output_gate_n, lower_byte_output_gate_n); // RULE_12
		end
	endgenerate
endmodule

// ==== rtl/sar_seq_pkg.sv ====
// Shared constants for the successive-approximation acquisition sequencer.
package sar_seq_pkg;
	// Result width per variant.
	localparam int unsigned WIDTH_14 = 14;
	localparam int unsigned WIDTH_15 = 15;
	// Clock period in picoseconds at 40 MHz.
	localparam int unsigned MCLK_PERIOD_PS = 25000;
	// Longest conversion time per variant, in microseconds.
	localparam int unsigned CONV_MAX_US_14 = 35;
	localparam int unsigned CONV_MAX_US_15 = 44;
	// Conversion time limits in mclk cycles, rounded down.
	localparam int unsigned CONV_MAX_CYC_14 = (CONV_MAX_US_14 * 1000000) / MCLK_PERIOD_PS;
	localparam int unsigned CONV_MAX_CYC_15 = (CONV_MAX_US_15 * 1000000) / MCLK_PERIOD_PS;
	// Least acquisition time per variant, in microseconds, kept for the host side.
	localparam int unsigned ACQ_MIN_US_14 = 4;
	localparam int unsigned ACQ_MIN_US_15 = 5;
	localparam int unsigned ACQ_MIN_CYC_14 = (ACQ_MIN_US_14 * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	localparam int unsigned ACQ_MIN_CYC_15 = (ACQ_MIN_US_15 * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	// Default mclk cycles per internal bit clock; a 14-bit conversion takes 15 ticks, 600 cycles, well below both limits.
	localparam int unsigned BIT_CLK_DIV = 40;
	// Result bits served by the lower byte gate.
	localparam int unsigned BYTE_BITS = 8;
	// Output coding selection.
	typedef enum logic [1:0] {
		CODE_STRAIGHT,
		CODE_OFFSET,
		CODE_TWOS
	} coding_t;
	// Sequencer states.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_TRIAL,
		ST_DONE
	} seq_state_t;
endpackage

// ==== sim/analog_front.sv ====
// Analog front end: tracks the input while sampling, compares it with the trial code.
module analog_front #(
	parameter int unsigned WIDTH = 14
) (
	input wire logic mclk,
	input wire logic hold,
	input wire logic [WIDTH-1:0] vin,
	input wire logic [WIDTH-1:0] dac_code,
	output logic comp_above
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [WIDTH-1:0] held_q;
	always_ff @(posedge mclk) begin
		if (!hold) begin
			held_q <= vin;
		end
	end
	assign comp_above = dac_code <= held_q;
endmodule

// ==== sim/sar_seq_asserts.sv ====
// Port checker for the acquisition sequencer.
module sar_seq_asserts #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned BIT_DIV = 40
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic convert,
	input wire logic hold,
	input wire logic [WIDTH-1:0] dac_code,
	input wire logic busy,
	input wire logic upper_byte_output_gate_n,
	input wire logic lower_byte_output_gate_n,
	input wire logic [WIDTH-1:0] data_out,
	input wire logic [WIDTH-1:0] data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BD = BIT_DIV;
	localparam int CONV_CYC = (WIDTH + 1) * BIT_DIV;
	localparam int LIMIT = (WIDTH > sar_seq_pkg::WIDTH_14) ? sar_seq_pkg::CONV_MAX_CYC_15 : sar_seq_pkg::CONV_MAX_CYC_14;
	localparam logic [WIDTH-1:0] START = {1'b0, {(WIDTH-1){1'b1}}};
	// Counts the edges at which busy has been seen high without a break.
	int run_q;
	always_ff @(posedge mclk) begin
		if (rst || !busy) begin
			run_q <= 0;
		end else begin
			run_q <= run_q + 1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence start_s;
		!busy && !convert && $past(convert) && !$past(rst);
	endsequence
	chk_track_mode: assert property (!busy && convert |-> !hold) else $error("hold");
	chk_hold_conv: assert property (busy |-> hold) else $error("sample");
	chk_start_code: assert property (start_s |=> busy && data_out == START) else $error("start");
	chk_busy_span: assert property ($fell(busy) |-> run_q == CONV_CYC) else $error("busy");
	chk_conv_limit: assert property (busy |-> run_q < LIMIT) else $error("limit");
	chk_first_trial: assert property (start_s |=> dac_code == START ##BD dac_code == ~START) else $error("trial");
	chk_conv_code: assert property (busy |-> data_out == START) else $error("running");
	chk_result_hold: assert property (!busy && !$past(busy) |-> $stable(data_out)) else $error("result");
	chk_gate_drive: assert property (1 |-> data_oe == {{(WIDTH-8){!upper_byte_output_gate_n}},
		{8{!lower_byte_output_gate_n}}}) else $error("gate");
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the acquisition sequencer.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned W = 14;
	localparam int unsigned DIV = 2;
	logic mclk = 0, rst = 1, convert = 1, hold, comp_above, busy;
	logic upper_byte_output_gate_n = 1, lower_byte_output_gate_n = 1;
	sar_seq_pkg::coding_t coding = sar_seq_pkg::CODE_STRAIGHT;
	logic [W-1:0] vin = '0, dac_code, data_out, data_oe, exp;
	logic [W-1:0] model_q[$];
	int seed = 65830, fails = 0, checked = 0, cyc = 0, k;
	always #12.5 mclk = ~mclk;
	sar_acquisition_sequencer #(.WIDTH(W), .BIT_DIV(DIV)) dut (.mclk, .rst, .convert, .coding, .hold, .comp_above,
		.dac_code, .busy, .upper_byte_output_gate_n, .lower_byte_output_gate_n, .data_out, .data_oe);
	analog_front #(.WIDTH(W)) front (.mclk, .hold, .vin, .dac_code, .comp_above);
	task automatic check(string what, logic [W-1:0] seen, logic [W-1:0] want);
		checked++;
		if (seen !== want) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		#2 rst = 0;
		for (int n = 0; n < 16; n++) begin
			vin = (n < 2) ? {W{n[0]}} : W'($random(seed));
			coding = sar_seq_pkg::coding_t'(n % 3);
			{upper_byte_output_gate_n, lower_byte_output_gate_n} = 2'($random(seed));
			exp = vin;
			if (coding == sar_seq_pkg::CODE_TWOS) exp[W-1] = ~exp[W-1];
			model_q.push_back(exp);
			repeat (sar_seq_pkg::ACQ_MIN_CYC_14 + 1) @(posedge mclk);
			#2 convert = 0;
			k = 0;
			do begin
				@(posedge mclk);
				#2 k++;
				if (k == 1) check("busy", busy, 1);
				if (k == 1) check("start", data_out, {1'b0, {(W-1){1'b1}}});
				if (k == 2 && n[0]) convert = 1;
				if (k == 5 && n[0]) convert = 0;
			end while (busy !== 0 && k < 100);
			check("cycles", W'(k), W'((W + 1) * DIV + 1));
			check("result", data_out, model_q.pop_front());
			check("enable", data_oe, {{(W-8){!upper_byte_output_gate_n}}, {8{!lower_byte_output_gate_n}}});
			convert = 1;
		end
		conclude();
	end
endmodule
bind sar_acquisition_sequencer sar_seq_asserts #(.WIDTH(WIDTH), .BIT_DIV(BIT_DIV)) checks (.mclk, .rst, .convert,
	.hold, .dac_code, .busy, .upper_byte_output_gate_n, .lower_byte_output_gate_n, .data_out, .data_oe);
